// ==== core/ocfr_top.sv ====
// Over-current fault response: action byte, response state machine and output enable.
// Assumes the command port is driven by PMBus slave logic on clk and the fault
// comparator output arrives asynchronously on a pin.
//
// What this block does
// - Response 00 ignores the fault entirely.
// - Response 01 runs on for delay, then disables, then retry policy.
// - Response 10 disables at once, then retry policy.
// - Response 11 disables only while fault persists.
// - Retry count 000 latches off until cleared.
// - Counts 1 to 6 allow that many attempts.
// - Attempt starts spaced by 2 to the delay field units.
// - Count 111 retries until off, bias, fault.
// - Delay field n means 2 to the n units.
`timescale 1ns/1ps
module ocfr_top
  import ocfr_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    cmd_valid,
  input  wire logic                    cmd_write,
  input  wire logic [7:0]              cmd_code,
  input  wire logic [7:0]              cmd_wdata,
  input  wire logic [OCFR_UNIT_W-1:0]  unit_cycles,
  input  wire logic                    fault_pin,
  input  wire logic                    fault_clear,
  input  wire logic                    on_command,
  input  wire logic                    bias_ok,
  input  wire logic                    other_fault_off,
  output logic                         output_enable_q,
  output logic                         latched_off_q,
  output logic                         rd_valid_q,
  output logic [7:0]                   rd_data_q
);

  // ==========================================================================
  // Field decoding
  // ==========================================================================
  function automatic logic [1:0] rsp_of(input logic [7:0] a);
    rsp_of = a[OCFR_RSP_MSB:OCFR_RSP_LSB];
  endfunction : rsp_of

  function automatic logic [2:0] retries_of(input logic [7:0] a);
    retries_of = a[OCFR_RETRY_MSB:OCFR_RETRY_LSB];
  endfunction : retries_of

  function automatic logic [2:0] delay_of(input logic [7:0] a);
    delay_of = a[OCFR_DELAY_MSB:OCFR_DELAY_LSB];
  endfunction : delay_of

  // ==========================================================================
  // Action byte register and read answer
  // ==========================================================================
  logic [7:0] action_q;
  logic       hit;

  assign hit = cmd_valid && (cmd_code == OCFR_ACTION_CODE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      action_q <= OCFR_ACTION_RESET;
    end else if (hit && cmd_write) begin
      action_q <= cmd_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= OCFR_UNMAPPED_RD;
    end else begin
      rd_valid_q <= cmd_valid && !cmd_write;
      if (cmd_valid && !cmd_write) begin
        rd_data_q <= hit ? action_q : OCFR_UNMAPPED_RD;
      end
    end
  end

  // ==========================================================================
  // Fault pin synchroniser
  // ==========================================================================
  logic fault_meta_q;
  logic fault_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_meta_q <= 1'b0;
      fault_q      <= 1'b0;
    end else begin
      fault_meta_q <= fault_pin;
      fault_q      <= fault_meta_q;
    end
  end

  // ==========================================================================
  // Delay timer
  // ==========================================================================
  logic timer_start;
  logic timer_done;

  ocfr_unit_timer u_timer (
    .clk         (clk),
    .resetn      (resetn),
    .start       (timer_start),
    .unit_cycles (unit_cycles),
    .units_log2  (delay_of(action_q)),
    .done_q      (timer_done)
  );

  // ==========================================================================
  // Response state machine
  // ==========================================================================
  ocfr_state_t state_q;
  ocfr_state_t state_d;
  logic [2:0]  attempts_q;
  logic        attempt_start;
  logic        budget_left;
  logic        stop_req;
  logic        clear_cnt;

  assign stop_req    = !on_command || !bias_ok || other_fault_off;
  assign budget_left = (retries_of(action_q) == OCFR_RETRY_FOREVER) ||
                       (attempts_q < retries_of(action_q));

  always_comb begin
    state_d       = state_q;
    timer_start   = 1'b0;
    attempt_start = 1'b0;
    clear_cnt     = 1'b0;
    unique case (state_q)
      OCFR_RUN: begin
        if (fault_q) begin
          unique case (rsp_of(action_q))
            OCFR_RSP_IGNORE: begin
              state_d = OCFR_RUN;
            end
            OCFR_RSP_DELAYED: begin
              state_d     = OCFR_DELAY;
              timer_start = 1'b1;
            end
            OCFR_RSP_SHUTDOWN: begin
              timer_start = 1'b1;
              state_d     = (retries_of(action_q) == OCFR_RETRY_NONE) ?
                            OCFR_LATCHED : OCFR_OFF_WAIT;
            end
            OCFR_RSP_HICCUP: begin
              state_d = OCFR_HICCUP;
            end
          endcase
        end
      end
      OCFR_DELAY: begin
        if (!fault_q) begin
          state_d = OCFR_RUN;
        end else if (timer_done) begin
          timer_start = 1'b1;
          state_d     = (retries_of(action_q) == OCFR_RETRY_NONE) ?
                        OCFR_LATCHED : OCFR_OFF_WAIT;
        end
      end
      OCFR_OFF_WAIT: begin
        if (stop_req) begin
          state_d = OCFR_LATCHED;
        end else if (timer_done) begin
          if (budget_left) begin
            state_d       = OCFR_TRY;
            timer_start   = 1'b1;
            attempt_start = 1'b1;
          end else begin
            state_d = OCFR_LATCHED;
          end
        end
      end
      OCFR_TRY: begin
        if (stop_req) begin
          state_d = OCFR_LATCHED;
        end else if (fault_q) begin
          state_d = budget_left ? OCFR_OFF_WAIT : OCFR_LATCHED;
        end else if (timer_done) begin
          state_d   = OCFR_RUN;
          clear_cnt = 1'b1;
        end
      end
      OCFR_LATCHED: begin
        if (fault_clear) begin
          state_d   = OCFR_RUN;
          clear_cnt = 1'b1;
        end
      end
      OCFR_HICCUP: begin
        if (!fault_q) begin
          state_d = OCFR_RUN;
        end
      end
      default: begin
        state_d = OCFR_LATCHED;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= OCFR_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Restart attempt counter
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      attempts_q <= '0;
    end else if (clear_cnt) begin
      attempts_q <= '0;
    end else if (attempt_start && attempts_q != OCFR_RETRY_FOREVER) begin
      attempts_q <= attempts_q + 3'h1;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_enable_q <= 1'b1;
      latched_off_q   <= 1'b0;
    end else begin
      output_enable_q <= (state_d == OCFR_RUN) || (state_d == OCFR_DELAY) ||
                         (state_d == OCFR_TRY);
      latched_off_q   <= (state_d == OCFR_LATCHED);
    end
  end

endmodule : ocfr_top

// ==== core/ocfr_pkg.sv ====
// Constants shared by the over-current fault response block and its unit timer.
// Assumes one clock domain; the delay unit length is supplied in clock cycles.
package ocfr_pkg;

  // ==========================================================================
  // Command code and reset value
  // ==========================================================================
  localparam logic [7:0] OCFR_ACTION_CODE  = 8'h47;
  localparam logic [7:0] OCFR_ACTION_RESET = 8'h80;
  localparam logic [7:0] OCFR_UNMAPPED_RD  = 8'h00;

  // ==========================================================================
  // Field layout of the action byte
  // ==========================================================================
  localparam int OCFR_RSP_MSB   = 7;
  localparam int OCFR_RSP_LSB   = 6;
  localparam int OCFR_RETRY_MSB = 5;
  localparam int OCFR_RETRY_LSB = 3;
  localparam int OCFR_DELAY_MSB = 2;
  localparam int OCFR_DELAY_LSB = 0;

  localparam logic [1:0] OCFR_RSP_IGNORE   = 2'h0;
  localparam logic [1:0] OCFR_RSP_DELAYED  = 2'h1;
  localparam logic [1:0] OCFR_RSP_SHUTDOWN = 2'h2;
  localparam logic [1:0] OCFR_RSP_HICCUP   = 2'h3;

  localparam logic [2:0] OCFR_RETRY_NONE    = 3'h0;
  localparam logic [2:0] OCFR_RETRY_MAX_CNT = 3'h4;
  localparam logic [2:0] OCFR_RETRY_FOREVER = 3'h7;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          OCFR_UNIT_W       = 16;
  localparam int          OCFR_COUNT_W      = 8;
  localparam logic [15:0] OCFR_UNIT_DEFAULT = 16'h0019;

  // ==========================================================================
  // Response state machine
  // ==========================================================================
  typedef enum logic [2:0] {
    OCFR_RUN      = 3'b000,
    OCFR_DELAY    = 3'b001,
    OCFR_OFF_WAIT = 3'b010,
    OCFR_TRY      = 3'b011,
    OCFR_LATCHED  = 3'b100,
    OCFR_HICCUP   = 3'b101
  } ocfr_state_t;

endpackage : ocfr_pkg

// ==== core/ocfr_unit_timer.sv ====
// Delay timer counting a power-of-two number of delay units.
// Assumes start is a one-cycle pulse on clk and unit_cycles is stable while running.
`timescale 1ns/1ps
module ocfr_unit_timer
  import ocfr_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    start,
  input  wire logic [OCFR_UNIT_W-1:0]  unit_cycles,
  input  wire logic [2:0]              units_log2,
  output logic                         done_q
);

  // ==========================================================================
  // Span counter
  // ==========================================================================
  localparam int SPAN_W = OCFR_UNIT_W + OCFR_COUNT_W;

  logic                   run_q;
  logic [SPAN_W-1:0]      rem_q;
  logic [SPAN_W-1:0]      span;
  logic [OCFR_UNIT_W-1:0] unit_len;

  // A zero unit length counts as one cycle.
  assign unit_len = (unit_cycles == '0) ? OCFR_UNIT_W'(1) : unit_cycles;
  // Delay field value n selects 2**n units.
  assign span     = SPAN_W'(unit_len) << units_log2;

  // Done is registered, so it rises one edge before the span ends and a restart
  // issued on it lands exactly one span after the previous start.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 1'b0;
      rem_q <= '0;
    end else if (start) begin
      run_q <= (span != SPAN_W'(1));
      rem_q <= span - SPAN_W'(1);
    end else if (run_q) begin
      rem_q <= rem_q - SPAN_W'(1);
      if (rem_q == SPAN_W'(1)) begin
        run_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= start ? (span == SPAN_W'(1)) : (run_q && (rem_q == SPAN_W'(1)));
    end
  end

endmodule : ocfr_unit_timer

// ==== dv/ocfr_asserts.sv ====
// Port checks for the over-current fault response block.
// Assumes one clock domain and the block's two-stage fault synchroniser.
`timescale 1ns/1ps
module ocfr_checker
  import ocfr_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       cmd_valid,
  input wire logic       cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire logic       fault_pin,
  input wire logic       fault_clear,
  input wire logic       on_command,
  input wire logic       bias_ok,
  input wire logic       other_fault_off,
  input wire logic       output_enable_q,
  input wire logic       latched_off_q,
  input wire logic       rd_valid_q,
  input wire logic [7:0] rd_data_q
);
  logic [7:0] cfg_q;
  logic       f1_q, f2_q;
  logic [1:0] rsp;
  logic [2:0] rty;
  assign rsp = cfg_q[7:6];
  assign rty = cfg_q[5:3];
  // ==========================================================================
  // Shadow of the action byte and of the synchronised fault
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cfg_q <= OCFR_ACTION_RESET;
    else if (cmd_valid && cmd_write && cmd_code == OCFR_ACTION_CODE) cfg_q <= cmd_wdata;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      f1_q <= 1'b0;
      f2_q <= 1'b0;
    end else begin
      f1_q <= fault_pin;
      f2_q <= f1_q;
    end
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_off_latch;
    !output_enable_q ##[0:60] latched_off_q;
  endsequence
  a_ignore_keeps_on: assert property (rsp == 2'h0 && output_enable_q && !cmd_valid
    |=> output_enable_q) else $error("output dropped while faults are ignored");
  a_delay_runs_on: assert property ($rose(f2_q) && rsp == 2'h1 && output_enable_q
    |=> output_enable_q [*2]) else $error("output dropped before the delay");
  a_shutdown_at_once: assert property ($rose(f2_q) && rsp == 2'h2 && output_enable_q
    |=> !output_enable_q) else $error("no immediate shutdown");
  a_hiccup_off: assert property ($rose(f2_q) && rsp == 2'h3 && output_enable_q
    |=> !output_enable_q) else $error("no disable while fault present");
  a_hiccup_resume: assert property ($fell(f2_q) && rsp == 2'h3 && !latched_off_q
    |-> ##[1:2] output_enable_q) else $error("no resume after fault cleared");
  a_no_retry_latch: assert property ($rose(f2_q) && rsp == 2'h2 && rty == 3'h0
    && output_enable_q |=> s_off_latch) else $error("no latch without retries");
  a_latched_holds: assert property (latched_off_q && !fault_clear
    |=> latched_off_q && !output_enable_q) else $error("latched off left early");
  a_clear_releases: assert property (latched_off_q && fault_clear
    |=> !latched_off_q) else $error("clear did not release latch");
  a_stop_latches: assert property (rsp == 2'h2 && rty == 3'h7 && !output_enable_q
    && !latched_off_q && (!on_command || !bias_ok || other_fault_off)
    |-> ##[1:3] latched_off_q) else $error("continuous retry did not stop");
  a_read_answer: assert property (cmd_valid && !cmd_write |=> rd_valid_q && rd_data_q ==
    ($past(cmd_code) == OCFR_ACTION_CODE ? $past(cfg_q) : OCFR_UNMAPPED_RD))
    else $error("wrong read answer");
  a_read_pulse: assert property (!(cmd_valid && !cmd_write) |=> !rd_valid_q)
    else $error("read valid without read");
endmodule : ocfr_checker

// ==== dv/ocfr_host.sv ====
// Host model issuing single-byte command port transfers.
// Assumes inputs are driven at the falling edge of clk.
`timescale 1ns/1ps
module ocfr_host (
  input  wire logic       clk,
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_wdata,
  input  wire logic       rd_valid_q,
  input  wire logic [7:0] rd_data_q
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
  end
  // Idle code and data show the inverse of the last value.
  task automatic xfer(input logic w, input logic [7:0] code, input logic [7:0] data,
                      output logic [7:0] rdat, output logic ok);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = code;
    cmd_wdata = data;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~data;
    ok = rd_valid_q;
    rdat = rd_data_q;
  endtask : xfer
endmodule : ocfr_host

// ==== dv/tb_top.sv ====
// Self-checking bench for the over-current fault response block.
// Assumes the host model drives the command port; fault inputs are driven here.
`timescale 1ns/1ps
module tb_top;
  import ocfr_pkg::*;
  logic       clk, resetn, fault_pin, fault_clear, on_command, bias_ok, other_fault_off;
  logic       cmd_valid, cmd_write, oe, lat, rv, ok;
  logic [7:0] cmd_code, cmd_wdata, rd, d;
  int         err_count = 0, samples_checked = 0, r, g, t;
  ocfr_top i_ocfr_top (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .unit_cycles(16'h0003), .fault_pin(fault_pin), .fault_clear(fault_clear),
    .on_command(on_command), .bias_ok(bias_ok), .other_fault_off(other_fault_off),
    .output_enable_q(oe), .latched_off_q(lat), .rd_valid_q(rv), .rd_data_q(rd));
  ocfr_host i_ocfr_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_valid_q(rv), .rd_data_q(rd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    i_ocfr_host.xfer(1'b1, code, data, d, ok);
  endtask : wr
  task automatic rdc(input logic [7:0] code, input logic [7:0] exp);
    i_ocfr_host.xfer(1'b0, code, 8'h00, d, ok);
    chk(ok, 1'b1);
    chk(d, exp);
  endtask : rdc
  task automatic fault(input int n, output int r, output int g, output int t);
    int   t1;
    logic p;
    r = 0;
    g = 0;
    t = -1;
    t1 = 0;
    p = 1'b1;
    fault_pin = 1'b1;
    for (int i = 0; i < n && lat !== 1'b1; i++) begin
      @(negedge clk);
      if (oe !== 1'b1 && t < 0) t = i;
      if (oe === 1'b1 && p === 1'b0) begin
        r++;
        if (r == 1) t1 = i;
        if (r == 2) g = i - t1;
      end
      p = oe;
    end
  endtask : fault
  task automatic recover;
    fault_pin = 1'b0;
    repeat (4) @(negedge clk);
    fault_clear = 1'b1;
    @(negedge clk);
    fault_clear = 1'b0;
    repeat (3) @(negedge clk);
    chk(lat, 1'b0);
    chk(oe, 1'b1);
  endtask : recover
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    #(40 * 40000);
    err_count++;
    complete_run();
  end
  initial begin
    resetn = 1'b0;
    fault_pin = 1'b0;
    fault_clear = 1'b0;
    on_command = 1'b1;
    bias_ok = 1'b1;
    other_fault_off = 1'b0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    rdc(OCFR_ACTION_CODE, OCFR_ACTION_RESET);
    wr(8'h48, 8'h5A);
    rdc(8'h48, OCFR_UNMAPPED_RD);
    rdc(OCFR_ACTION_CODE, OCFR_ACTION_RESET);
    wr(OCFR_ACTION_CODE, 8'h00);
    fault(60, r, g, t);
    chk(t, -1);
    recover();
    wr(OCFR_ACTION_CODE, 8'hC0);
    fault_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk(oe, 1'b0);
    fault_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk(oe, 1'b1);
    wr(OCFR_ACTION_CODE, 8'h43);
    fault(200, r, g, t);
    chk(t >= 24 && t <= 32, 1'b1);
    chk(lat, 1'b1);
    recover();
    for (int n = 0; n < 5; n++) begin
      wr(OCFR_ACTION_CODE, {2'h2, n[2:0], n[2:0]});
      rdc(OCFR_ACTION_CODE, {2'h2, n[2:0], n[2:0]});
      fault(1000, r, g, t);
      chk(r, n);
      chk(lat, 1'b1);
      if (n >= 2) chk(g, 3 << n);
      recover();
    end
    for (int k = 0; k < 3; k++) begin
      wr(OCFR_ACTION_CODE, 8'hB8);
      fault(150, r, g, t);
      chk(r > 8, 1'b1);
      chk(lat, 1'b0);
      if (k == 0) on_command = 1'b0;
      else if (k == 1) bias_ok = 1'b0;
      else other_fault_off = 1'b1;
      repeat (20) @(negedge clk);
      chk(lat, 1'b1);
      on_command = 1'b1;
      bias_ok = 1'b1;
      other_fault_off = 1'b0;
      recover();
    end
    complete_run();
  end
endmodule : tb_top

bind ocfr_top ocfr_checker i_ocfr_checker (.clk, .resetn, .cmd_valid, .cmd_write, .cmd_code,
  .cmd_wdata, .fault_pin, .fault_clear, .on_command, .bias_ok, .other_fault_off,
  .output_enable_q, .latched_off_q, .rd_valid_q, .rd_data_q);
